// ===== verilog/shs_host_serial_port.sv
// Slave-only host serial port: 4-wire full duplex or I2C pin roles
`timescale 1ns/1ps
`include "shs_cfg.svh"
// What this block does
// - Transfers are organised as 8-bit bytes
// - Port is slave only, never drives clock
// - I2C: data pin never driven here, address pins inputs
// - 4-wire: output driven while selected, else released
// - Format pin high at reset picks 4-wire
// - Write byte in while read byte goes out
// - MSB first, active only while select low
// - Sample input on serial clock rising edges
// - Output changes on falling edges; MSB at select
// - Short transfer passes bits right-aligned at release
// - Long transfer keeps only last eight bits
// - After LSB, echo received bits until release
// - Format pin low at reset picks I2C
module shs_host_serial_port #(
  parameter int BYTE_W = `SHS_BYTE_W
) (
  input wire logic clock,
  input wire logic reset_n,
  // Shared pins
  input wire logic host_sck,
  input wire logic host_select_n,
  input wire logic host_serial_in,
  input wire logic format_select_pin,
  input wire logic host_serial_out_i,
  output logic host_serial_out_o,
  output logic host_serial_out_oe,
  // Core side
  input wire logic [BYTE_W-1:0] tx_byte,
  output logic tx_taken,
  output logic [BYTE_W-1:0] rx_byte,
  output logic rx_valid,
  output logic [`SHS_CNT_W-1:0] rx_bits,
  output logic format_select,
  output logic [1:0] i2c_addr,
  output logic i2c_scl_level,
  output logic i2c_sda_level
);

  // Byte width is fixed by the protocol
  if (BYTE_W != `SHS_BYTE_W) begin : g_bad_width
    $error("shs_host_serial_port supports only 8-bit units");
  end

  shs_pin_if #(.W(`SHS_PIN_N)) pin_if ();

  logic [`SHS_PIN_N-1:0] pins;
  shs_pkg::shs_format_t fmt_q;
  shs_pkg::shs_state_t state_q;
  logic [BYTE_W-1:0] shift_q;
  logic [BYTE_W-1:0] rx_q;
  logic [`SHS_CNT_W-1:0] cnt_q;
  logic sdo_q;
  logic [BYTE_W-1:0] rx_byte_q;
  logic rx_valid_q;
  logic tx_taken_q;
  logic [`SHS_CNT_W-1:0] rx_bits_q;
  logic four_wire;
  logic sel_fall;
  logic sel_rise;
  logic sck_rise;
  logic sck_fall;
  logic selected;

  // Every outside pin passes two flops before any logic reads it
  always_comb begin
    pins = '0;
    pins[`SHS_PIN_SCK] = host_sck;
    pins[`SHS_PIN_SEL_N] = host_select_n;
    pins[`SHS_PIN_HOST_SERIAL_IN] = host_serial_in;
    pins[`SHS_PIN_FMT] = format_select_pin;
    pins[`SHS_PIN_SDA] = host_serial_out_i;
    pins[`SHS_PIN_SCL] = host_sck;
  end

  shs_pin_sync #(
    .W(`SHS_PIN_N),
    .STAGES(`SHS_SYNC_STAGES)
  ) u_sync (
    .clock(clock),
    .pins(pins),
    .sync(pin_if)
  );

  // Format caught from the synchronised pin while reset is held
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      if (pin_if.level[`SHS_PIN_FMT]) begin
        fmt_q <= shs_pkg::SHS_FMT_4WIRE;
      end else begin
        fmt_q <= shs_pkg::SHS_FMT_I2C;
      end
    end
  end

  // Edge events, only in 4-wire format; the host owns the clock
  assign four_wire = (fmt_q == shs_pkg::SHS_FMT_4WIRE);
  assign sel_fall = four_wire && pin_if.fall[`SHS_PIN_SEL_N];
  assign sel_rise = four_wire && pin_if.rise[`SHS_PIN_SEL_N];
  assign selected = four_wire && !pin_if.level[`SHS_PIN_SEL_N];
  assign sck_rise = pin_if.rise[`SHS_PIN_SCK] && (state_q == shs_pkg::SHS_SHIFT);
  assign sck_fall = pin_if.fall[`SHS_PIN_SCK] && (state_q == shs_pkg::SHS_SHIFT);

  // Transfer state: idle, shifting while selected, one-cycle hand-off
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      state_q <= shs_pkg::SHS_IDLE;
    end else begin
      unique case (state_q)
        shs_pkg::SHS_IDLE: begin
          if (sel_fall) begin
            state_q <= shs_pkg::SHS_SHIFT;
          end
        end
        shs_pkg::SHS_SHIFT: begin
          if (sel_rise) begin
            state_q <= shs_pkg::SHS_DONE;
          end
        end
        shs_pkg::SHS_DONE: begin
          state_q <= shs_pkg::SHS_IDLE;
        end
        default: begin
          state_q <= shs_pkg::SHS_IDLE;
        end
      endcase
    end
  end

  // One register serves both directions: input enters at the LSB while
  // the MSB goes out, so after eight pulses the echo comes for free
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      shift_q <= `SHS_BYTE_RST;
    end else if (sel_fall && state_q == shs_pkg::SHS_IDLE) begin
      shift_q <= tx_byte;
    end else if (sck_rise) begin
      shift_q <= {shift_q[BYTE_W-2:0], pin_if.level[`SHS_PIN_HOST_SERIAL_IN]};
    end
  end

  // Receive register starts cleared, so a short transfer is right-aligned
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      rx_q <= `SHS_BYTE_RST;
    end else if (sel_fall && state_q == shs_pkg::SHS_IDLE) begin
      rx_q <= `SHS_BYTE_RST;
    end else if (sck_rise) begin
      rx_q <= {rx_q[BYTE_W-2:0], pin_if.level[`SHS_PIN_HOST_SERIAL_IN]};
    end
  end

  // Pulse counter saturates past a full byte; also blocks the hand-off of a frame with no pulses
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      cnt_q <= '0;
    end else if (sel_fall && state_q == shs_pkg::SHS_IDLE) begin
      cnt_q <= '0;
    end else if (sck_rise && cnt_q != `SHS_FULL_CNT) begin
      cnt_q <= cnt_q + `SHS_CNT_W'(1);
    end
  end

  // Output bit: MSB at select fall, then each falling clock edge
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      sdo_q <= `SHS_BIT_RST;
    end else if (sel_fall && state_q == shs_pkg::SHS_IDLE) begin
      sdo_q <= tx_byte[BYTE_W-1];
    end else if (sck_fall) begin
      sdo_q <= shift_q[BYTE_W-1];
    end
  end

  // Byte handed to the core when select rises, with pulse count
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      rx_byte_q <= `SHS_BYTE_RST;
      rx_bits_q <= '0;
      rx_valid_q <= 1'b0;
    end else begin
      rx_valid_q <= 1'b0;
      if (sel_rise && state_q == shs_pkg::SHS_SHIFT && cnt_q != '0) begin
        rx_byte_q <= rx_q;
        rx_bits_q <= cnt_q;
        rx_valid_q <= 1'b1;
      end
    end
  end

  // Tells the core its byte was loaded for sending
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      tx_taken_q <= 1'b0;
    end else begin
      tx_taken_q <= sel_fall && (state_q == shs_pkg::SHS_IDLE);
    end
  end

  // Pin drivers: push-pull while selected in 4-wire, never driven in I2C
  // because the I2C engine lies outside and pulls low through its own path
  always_comb begin
    host_serial_out_o = sdo_q;
    host_serial_out_oe = selected;
    if (!four_wire) begin
      host_serial_out_o = 1'b0;
      host_serial_out_oe = 1'b0;
    end
  end

  // I2C roles: address pins and bus lines as plain synchronised inputs
  always_comb begin
    i2c_addr = 2'h0;
    i2c_scl_level = 1'b1;
    i2c_sda_level = 1'b1;
    if (!four_wire) begin
      i2c_addr = {pin_if.level[`SHS_PIN_SEL_N], pin_if.level[`SHS_PIN_HOST_SERIAL_IN]};
      i2c_scl_level = pin_if.level[`SHS_PIN_SCL];
      i2c_sda_level = pin_if.level[`SHS_PIN_SDA];
    end
  end

  assign rx_byte = rx_byte_q;
  assign rx_valid = rx_valid_q;
  assign rx_bits = rx_bits_q;
  assign tx_taken = tx_taken_q;
  assign format_select = fmt_q;

endmodule

// ===== verilog/shs_cfg.svh
// Constants of the host serial port: widths, codes and sync depth
`ifndef SHS_CFG_SVH
`define SHS_CFG_SVH

// Bits in one transferred unit
`define SHS_BYTE_W 8
// Width of the saturating clock-pulse counter
`define SHS_CNT_W 4
// Pulse count that completes one full byte
`define SHS_FULL_CNT 4'h8
// Flip-flops in each pin synchroniser
`define SHS_SYNC_STAGES 2
// Number of pins passed through the synchroniser
`define SHS_PIN_N 6
// Bit positions of the pins in the synchronised vector
`define SHS_PIN_SCK 0
`define SHS_PIN_SEL_N 1
`define SHS_PIN_HOST_SERIAL_IN 2
`define SHS_PIN_FMT 3
`define SHS_PIN_SDA 4
`define SHS_PIN_SCL 5
// Reset value of the received byte and the outgoing bit
`define SHS_BYTE_RST 8'h00
`define SHS_BIT_RST 1'h1

`endif

// ===== verilog/shs_pkg.sv
// Types shared by the host serial port modules
package shs_pkg;

  // Serial format picked at reset
  typedef enum logic {
    SHS_FMT_I2C = 1'b0,
    SHS_FMT_4WIRE = 1'b1
  } shs_format_t;

  // 4-wire transfer state, Gray coded
  typedef enum logic [1:0] {
    SHS_IDLE = 2'b00,
    SHS_SHIFT = 2'b01,
    SHS_DONE = 2'b11
  } shs_state_t;

endpackage

// ===== verilog/shs_pin_if.sv
// Synchronised pin levels and their edges, between synchroniser and port logic
`timescale 1ns/1ps
interface shs_pin_if #(
  parameter int W = 6
);
  logic [W-1:0] level;
  logic [W-1:0] rise;
  logic [W-1:0] fall;

  modport src (output level, output rise, output fall);
  modport dst (input level, input rise, input fall);
endinterface

// ===== verilog/shs_pin_sync.sv
// Multi-stage pin synchroniser with single-cycle edge pulses
`timescale 1ns/1ps
module shs_pin_sync #(
  parameter int W = 6,
  parameter int STAGES = 2
) (
  input wire logic clock,
  input wire logic [W-1:0] pins,
  shs_pin_if.src sync
);

  logic [W-1:0] chain_q [STAGES];
  logic [W-1:0] prev_q;

  // Fewer than two stages would let a metastable level reach the logic
  if (STAGES < 2) begin : g_bad_stages
    $error("shs_pin_sync needs at least two stages");
  end

  // No reset: the chain just follows the pins, reset keeps edges unused
  always_ff @(posedge clock) begin
    chain_q[0] <= pins;
    for (int i = 1; i < STAGES; i++) begin
      chain_q[i] <= chain_q[i-1];
    end
  end

  // Delayed copy of the settled level for edge detection
  always_ff @(posedge clock) begin
    prev_q <= chain_q[STAGES-1];
  end

  // Each edge shows for exactly one cycle
  assign sync.level = chain_q[STAGES-1];
  assign sync.rise = chain_q[STAGES-1] & ~prev_q;
  assign sync.fall = ~chain_q[STAGES-1] & prev_q;

endmodule

// ===== tb/shs_asserts.sv
// Timing and relation checks on the host serial port pins
`timescale 1ns/1ps
`include "shs_cfg.svh"
module shs_asserts (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic host_sck,
  input wire logic host_select_n,
  input wire logic host_serial_out_o,
  input wire logic host_serial_out_oe,
  input wire logic rx_valid,
  input wire logic [`SHS_CNT_W-1:0] rx_bits,
  input wire logic format_select
);
  default clocking @(posedge clock); endclocking
  default disable iff (!reset_n);
  // Windows of 4-5 cycles cover the two-flop sync plus edge detect
  a_i2c_no_drive: assert property (!format_select |-> !host_serial_out_oe)
    else $error("data pin driven in two-wire format");
  a_oe_off_idle: assert property ((format_select && host_select_n)[*4] |-> !host_serial_out_oe)
    else $error("output driven while deselected");
  a_oe_on_sel: assert property ((format_select && !host_select_n)[*4] |-> host_serial_out_oe)
    else $error("output released while selected");
  a_fmt_held: assert property ($stable(format_select))
    else $error("format changed outside reset");
  a_rx_after_rise: assert property (rx_valid |-> $past(host_select_n, 3))
    else $error("hand-off without select release");
  a_rx_bit_count: assert property (rx_valid |-> rx_bits != 4'h0 && rx_bits <= 4'h8)
    else $error("bad pulse count at hand-off");
  a_no_rx_i2c: assert property (!format_select |-> !rx_valid)
    else $error("hand-off in two-wire format");
  // Output may only move a few cycles after a clock fall or a select fall
  a_out_hold_high: assert property ((!host_select_n && host_sck)[*5] |-> $stable(host_serial_out_o))
    else $error("output moved while clock high");
endmodule

bind shs_host_serial_port shs_asserts chk_u (.clock, .reset_n, .host_sck, .host_select_n,
  .host_serial_out_o, .host_serial_out_oe, .rx_valid, .rx_bits, .format_select);

// ===== tb/shs_host_model.sv
// Behavioural host master for the 4-wire port
`timescale 1ns/1ps
module shs_host_model (
  output logic sck,
  output logic sel_n,
  output logic sdi,
  input wire logic sdo
);
  // Clock stands low and select high between frames
  initial begin
    sck = 1'b0;
    sel_n = 1'b1;
    sdi = 1'b0;
  end
  // One frame of n bits, MSB first, output sampled at clock rise
  task automatic xfer(input int n, input logic [15:0] din, output logic [15:0] dout);
    dout = 16'h0000;
    sel_n = 1'b0;
    #100;
    for (int i = n - 1; i >= 0; i--) begin
      sdi = din[i];
      #40;
      sck = 1'b1;
      dout = {dout[14:0], sdo};
      #40;
      sck = 1'b0;
    end
    #40;
    sel_n = 1'b1;
    // Released data shows the inverse so stale values cannot pass
    sdi = ~sdi;
    #60;
  endtask
endmodule

// ===== tb/testbench.sv
// Self-checking bench for the host serial port
`timescale 1ns/1ps
module testbench;
  logic clock = 1'b0;
  logic reset_n = 1'b0;
  logic fmt_pin = 1'b1;
  logic [7:0] tx_byte = 8'h00;
  logic sck, sel_n, sdi, sdo_o, sdo_oe, rx_valid, fmt;
  logic tx_taken, scl_lvl, sda_lvl;
  logic [7:0] rx_byte, got;
  logic [3:0] rx_bits, got_n;
  logic [1:0] addr;
  logic [15:0] d;
  int error_cnt = 0;
  int total_checks = 0;
  int rx_cnt = 0;
  int tx_cnt = 0;
  int kt;
  int k;
  // Pull-up holds the line high when released
  wire logic sdo_line = sdo_oe ? sdo_o : 1'b1;
  always #2.5 clock = ~clock;
  shs_host_serial_port dut_u (.clock(clock), .reset_n(reset_n), .host_sck(sck),
    .host_select_n(sel_n), .host_serial_in(sdi), .format_select_pin(fmt_pin),
    .host_serial_out_i(sdo_line), .host_serial_out_o(sdo_o), .host_serial_out_oe(sdo_oe),
    .tx_byte(tx_byte), .tx_taken(tx_taken), .rx_byte(rx_byte), .rx_valid(rx_valid),
    .rx_bits(rx_bits), .format_select(fmt), .i2c_addr(addr), .i2c_scl_level(scl_lvl),
    .i2c_sda_level(sda_lvl));
  shs_host_model model_u (.sck(sck), .sel_n(sel_n), .sdi(sdi), .sdo(sdo_line));
  // Hand-off pulses last one cycle, so catch them here
  always @(posedge clock) begin
    if (rx_valid === 1'b1) begin
      got <= rx_byte;
      got_n <= rx_bits;
      rx_cnt <= rx_cnt + 1;
    end
  end
  // Load acknowledges also last one cycle
  always @(posedge clock) begin
    if (tx_taken === 1'b1) begin
      tx_cnt <= tx_cnt + 1;
    end
  end
  task automatic chk(input logic [15:0] v, input logic [15:0] e);
    total_checks++;
    if (v !== e) begin
      error_cnt++;
      $display("mismatch %0t got %h exp %h", $time, v, e);
    end
  endtask
  task automatic stop_test();
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic rst(input logic f);
    reset_n = 1'b0;
    fmt_pin = f;
    repeat (6) @(posedge clock);
    #1;
    reset_n = 1'b1;
    repeat (4) @(posedge clock);
    #1;
  endtask
  // Frame and count the hand-offs it produced
  task automatic run(input int n, input logic [15:0] din, input logic [7:0] tx);
    k = rx_cnt;
    kt = tx_cnt;
    tx_byte = tx;
    model_u.xfer(n, din, d);
    repeat (8) @(posedge clock);
    #1;
    k = rx_cnt - k;
    kt = tx_cnt - kt;
  endtask
  task automatic t_full();
    chk(16'(sdo_oe), 16'h0);
    run(8, 16'h003c, 8'ha5);
    chk(d, 16'h00a5);
    chk({8'h00, got}, 16'h003c);
    chk(16'(k), 16'h1);
    chk({12'h000, got_n}, 16'h0008);
    chk(16'(kt), 16'h1);
    chk({12'h000, scl_lvl, sda_lvl, addr}, 16'h000c);
  endtask
  task automatic t_short();
    run(3, 16'h0005, 8'hc3);
    chk(d, 16'h0006);
    chk({8'h00, got}, 16'h0005);
    chk({12'h000, got_n}, 16'h0003);
  endtask
  task automatic t_long();
    run(12, 16'h0b6d, 8'h5a);
    chk(d, 16'h05ab);
    chk({8'h00, got}, 16'h006d);
    chk({12'h000, got_n}, 16'h0008);
  endtask
  task automatic t_zero();
    run(0, 16'h0000, 8'h81);
    chk(16'(k), 16'h0);
    chk(16'(kt), 16'h1);
  endtask
  task automatic t_i2c();
    rst(1'b0);
    chk(16'(fmt), 16'h0);
    model_u.sel_n = 1'b0;
    model_u.sdi = 1'b1;
    repeat (5) @(posedge clock);
    #1;
    chk({14'h0000, addr}, 16'h0001);
    chk({14'h0000, scl_lvl, sda_lvl}, 16'h0001);
    run(8, 16'h00f0, 8'h11);
    chk(16'(k), 16'h0);
    chk(16'(sdo_oe), 16'h0);
    chk(16'(kt), 16'h0);
    chk(d, 16'h00ff);
  endtask
  // Tests take about 4 us; a hang beyond 100 us is cut short
  initial begin
    #100000;
    error_cnt++;
    stop_test();
  end
  initial begin
    rst(1'b1);
    chk(16'(fmt), 16'h1);
    t_full();
    t_short();
    t_long();
    t_zero();
    t_i2c();
    stop_test();
  end
endmodule
